// ---- acc_analog_model.sv ----
// Behavioural model of the comparator input pins and reference sources.
module acc_analog_model #(
    parameter int VREF_MV = 2560,
    parameter int DAC_MV = 500,
    parameter int PIN_MV = 1500
) (
    // Reference choice from the control block.
    input wire logic [3*acc_pkg::UNITS-1:0] negative_source_select,
    // Positive input levels in millivolts.
    input var int pos_mv [acc_pkg::UNITS],
    // Comparator decisions.
    output logic [acc_pkg::UNITS-1:0] compare_raw
);
    // Threshold for one code; the reserved code never lets the output rise.
    function automatic int neg_mv(input logic [2:0] sel);
        case (sel)
            3'h0: return VREF_MV * 100 / 640;
            3'h1: return VREF_MV * 100 / 320;
            3'h2: return VREF_MV * 100 / 213;
            3'h3: return VREF_MV * 100 / 160;
            3'h4: return 1100;
            3'h5: return DAC_MV;
            3'h6: return PIN_MV;
            default: return 32'h7fffffff;
        endcase
    endfunction : neg_mv

    // High only while the positive input is above the chosen threshold.
    always_comb begin
        for (int i = 0; i < acc_pkg::UNITS; i++) begin
            compare_raw[i] = pos_mv[i] > neg_mv(negative_source_select[3*i+:3]);
        end
    end
endmodule : acc_analog_model

// ---- acc_control.sv ----
// Register file, flags and routing for four clocked analog comparators.
// Function
// R1 - Four comparators; output high when positive input exceeds chosen negative source.
// R2 - Bits 2..0 select negative source; code 111 is reserved.
// R3 - Bits 5..4 select toggle, falling or rising edge; 01 is reserved.
// R4 - Bit 7 enables the comparator.
// R5 - Bit 6 allows the comparator interrupt request.
// R6 - Each comparator has its own interrupt request line.
// R7 - Each interrupt flag is offered as a converter trigger.
// R8 - Unit 0 bit 3 picks PLL clock when set, I/O clock when clear.
// R9 - Unit 1 bit 3 routes comparator 1 to the timer capture front end.
// R10 - With routing on, capture edge follows the timer edge select.
// R11 - With routing off, nothing reaches the timer capture logic.
// R12 - Software sets the timer capture mask to get a capture interrupt.
// R13 - Amp route bits feed positive input from amplifier, clock doubled.
// R14 - Flag set on event, cleared on serviced interrupt or writing one.
// R15 - Sample and edge detect outputs; reserved codes raise no flag.
// R16 - Control registers reset to zero.
//
// Decided for this implementation: the placing of the registers and the strobed register port.
module acc_control (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic reset,
    // Register port.
    input wire logic [acc_pkg::AW-1:0] reg_addr,
    input wire logic [acc_pkg::DW-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [acc_pkg::DW-1:0] reg_rdata,
    // Raw comparator outputs from the analog cells.
    input wire logic [acc_pkg::UNITS-1:0] compare_raw,
    // Interrupt service acknowledge, one per unit.
    input wire logic [acc_pkg::UNITS-1:0] irq_ack,
    // Timer capture edge select from the timer.
    input wire logic timer_capture_edge_select,
    // Analog controls.
    output logic [acc_pkg::UNITS-1:0] unit_enable,
    output logic [3*acc_pkg::UNITS-1:0] negative_source_select,
    output logic compare_clock_select,
    output logic [acc_pkg::AMP_UNITS-1:0] amp_route,
    // Results, interrupts and triggers.
    output logic [acc_pkg::UNITS-1:0] compare_result_bit,
    output logic [acc_pkg::UNITS-1:0] unit_irq,
    output logic [acc_pkg::UNITS-1:0] conversion_trigger,
    output logic irq,
    // Timer capture front end.
    output logic capture_input,
    output logic capture_event
);
    typedef struct packed {
        logic [acc_pkg::UNITS-1:0][7:0] ctrl;
        logic [acc_pkg::UNITS-1:0] flag;
        logic [acc_pkg::UNITS-1:0] mask;
        logic [acc_pkg::AMP_UNITS-1:0] amp;
        logic [7:0] rdata;
        logic [acc_pkg::UNITS-1:0] uirq;
        logic irq;
        logic cap_in;
        logic cap_evt;
    } acc_state_t;

    acc_state_t st;
    acc_state_t next_st;

    logic [acc_pkg::UNITS-1:0] res;
    logic [acc_pkg::UNITS-1:0] evt;
    logic [acc_pkg::UNITS-1:0] rise;
    logic [acc_pkg::UNITS-1:0] fall;

    // One sampler per comparator, all on the system clock.
    genvar gi;
    generate
        for (gi = 0; gi < acc_pkg::UNITS; gi++) begin : g_unit
            acc_edge_detect u_edge (
                .clk_sys(clk_sys),
                .reset(reset),
                .raw_in(compare_raw[gi]),
                .enable(st.ctrl[gi][acc_pkg::ENABLE_POS]),
                .sense(st.ctrl[gi][acc_pkg::SENSE_HI:acc_pkg::SENSE_LO]),
                .neg_sel(st.ctrl[gi][acc_pkg::NEG_HI:0]),
                .result(res[gi]),
                .event_pulse(evt[gi]),
                .rise(rise[gi]),
                .fall(fall[gi])
            ); // R15
        end
    endgenerate

    // Next state: register writes, flag updates, read data and derived outputs.
    always_comb begin
        logic wr_status;
        logic [acc_pkg::UNITS-1:0] clr;
        next_st = st;
        wr_status = reg_write && (reg_addr == acc_pkg::ADDR_STATUS);
        clr = '0;
        // Control writes; units 2 and 3 have no bit 3, so it stays zero.
        if (reg_write) begin
            unique case (reg_addr)
                acc_pkg::ADDR_CTRL0: next_st.ctrl[0] = reg_wdata; // R2 R3 R4 R5 R8
                acc_pkg::ADDR_CTRL1: next_st.ctrl[1] = reg_wdata; // R9
                acc_pkg::ADDR_CTRL2: next_st.ctrl[2] = reg_wdata & acc_pkg::CTRL_PLAIN_MASK;
                acc_pkg::ADDR_CTRL3: next_st.ctrl[3] = reg_wdata & acc_pkg::CTRL_PLAIN_MASK;
                acc_pkg::ADDR_MASK: next_st.mask = reg_wdata[acc_pkg::UNITS-1:0];
                acc_pkg::ADDR_AMP: next_st.amp = reg_wdata[acc_pkg::AMP_UNITS-1:0]; // R13
                default: next_st.mask = st.mask;
            endcase
        end
        // A flag clears by a written one or a serviced interrupt, but a new event wins.
        for (int i = 0; i < acc_pkg::UNITS; i++) begin
            clr[i] = (wr_status && reg_wdata[acc_pkg::FLAG_POS+i])
                || (irq_ack[i] && st.ctrl[i][acc_pkg::IRQ_EN_POS]); // R14
            next_st.flag[i] = evt[i] | (st.flag[i] & ~clr[i]); // R14
        end
        // Read data stand for one cycle only; unmapped addresses read zero.
        next_st.rdata = 8'h00;
        if (reg_read) begin
            unique case (reg_addr)
                acc_pkg::ADDR_CTRL0: next_st.rdata = st.ctrl[0];
                acc_pkg::ADDR_CTRL1: next_st.rdata = st.ctrl[1];
                acc_pkg::ADDR_CTRL2: next_st.rdata = st.ctrl[2];
                acc_pkg::ADDR_CTRL3: next_st.rdata = st.ctrl[3];
                acc_pkg::ADDR_STATUS: next_st.rdata = {st.flag, res}; // R1
                acc_pkg::ADDR_MASK: next_st.rdata = {4'h0, st.mask};
                acc_pkg::ADDR_AMP: next_st.rdata = {5'h00, st.amp};
                default: next_st.rdata = 8'h00;
            endcase
        end
        // Per-unit request lines follow the flag and the unit's own enable.
        for (int i = 0; i < acc_pkg::UNITS; i++) begin
            next_st.uirq[i] = next_st.flag[i] & next_st.ctrl[i][acc_pkg::IRQ_EN_POS]; // R5 R6
        end
        next_st.irq = |(next_st.flag & next_st.mask);
        // Capture path is cut off entirely unless routing is on.
        next_st.cap_in = st.ctrl[1][acc_pkg::BIT3_POS] & res[1]; // R9 R11
        next_st.cap_evt = st.ctrl[1][acc_pkg::BIT3_POS]
            & (timer_capture_edge_select ? rise[1] : fall[1]); // R10 R11
    end

    // All control state clears at reset, so comparators start disabled.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            st.ctrl <= {acc_pkg::UNITS{acc_pkg::CTRL_RESET}}; // R16
            st.flag <= acc_pkg::FLAG_RESET;
            st.mask <= acc_pkg::MASK_RESET;
            st.amp <= acc_pkg::AMP_RESET;
            st.rdata <= 8'h00;
            st.uirq <= 4'h0;
            st.irq <= 1'b0;
            st.cap_in <= 1'b0;
            st.cap_evt <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // Outputs come straight from state flip-flops.
    generate
        for (gi = 0; gi < acc_pkg::UNITS; gi++) begin : g_out
            assign unit_enable[gi] = st.ctrl[gi][acc_pkg::ENABLE_POS]; // R4
            assign negative_source_select[3*gi +: 3] = st.ctrl[gi][acc_pkg::NEG_HI:0]; // R2
        end
    endgenerate
    assign compare_clock_select = st.ctrl[0][acc_pkg::BIT3_POS]; // R8
    // The clock generator doubles the amplifier clock for each routed unit.
    assign amp_route = st.amp; // R13
    assign compare_result_bit = res; // R1
    assign unit_irq = st.uirq; // R6
    assign conversion_trigger = st.flag; // R7
    assign irq = st.irq;
    assign reg_rdata = st.rdata;
    // The timer still needs its own capture mask set to interrupt.
    assign capture_input = st.cap_in; // R9 R12
    assign capture_event = st.cap_evt;

    // Checks on the observable behaviour, all in the system clock domain.
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);

    // Short names for the unit 0 fields that the checks watch.
    logic [1:0] chk_sense0;
    logic [2:0] chk_neg0;
    assign chk_sense0 = st.ctrl[0][acc_pkg::SENSE_HI:acc_pkg::SENSE_LO];
    assign chk_neg0 = st.ctrl[0][acc_pkg::NEG_HI:0];

    // A one written to the flag bit of unit 0.
    sequence s_w1c0;
        reg_write && reg_addr == acc_pkg::ADDR_STATUS && reg_wdata[acc_pkg::FLAG_POS];
    endsequence

    // Result 0 rises while its settings hold still.
    sequence s_rise0;
        !compare_result_bit[0] ##1 compare_result_bit[0] && $stable(st.ctrl[0]);
    endsequence

    // Result 0 falls while its settings hold still.
    sequence s_fall0;
        compare_result_bit[0] ##1 !compare_result_bit[0] && $stable(st.ctrl[0]);
    endsequence

    // Result 1 rises while routed to the timer.
    sequence s_rise1_routed;
        !compare_result_bit[1] ##1 compare_result_bit[1] && st.ctrl[1][acc_pkg::BIT3_POS];
    endsequence

    // An event sets the flag even beside a clear.
    a_flag_set: assert property (evt[0] |=> st.flag[0]) // R14
        else $error("flag 0 not set by event");

    // A written one clears the flag.
    a_flag_w1c: assert property (s_w1c0 and !evt[0] |=> !st.flag[0]) // R14
        else $error("flag 0 not cleared by write");

    // Service clears the flag only while requests are allowed.
    a_flag_ack: assert property (irq_ack[1] && st.ctrl[1][acc_pkg::IRQ_EN_POS] // R14
        && !evt[1] |=> !st.flag[1])
        else $error("flag 1 not cleared by service");

    // Without a clear, a set flag holds.
    a_flag_hold: assert property (st.flag[0] && !irq_ack[0] // R14
        && !reg_write |=> st.flag[0])
        else $error("flag 0 dropped without a clear");

    // A rise under rising sensitivity sets the flag.
    a_rise_flag: assert property (s_rise0 ##0 (chk_sense0 == acc_pkg::SENSE_RISE // R3
        && chk_neg0 != acc_pkg::NEG_RSVD) |=> st.flag[0])
        else $error("rising result did not set flag 0");

    // A fall under falling sensitivity sets the flag.
    a_fall_flag: assert property (s_fall0 ##0 (chk_sense0 == acc_pkg::SENSE_FALL // R3
        && chk_neg0 != acc_pkg::NEG_RSVD) |=> st.flag[0])
        else $error("falling result did not set flag 0");

    // Toggle sensitivity fires on either edge and nothing else.
    a_toggle_event: assert property (chk_sense0 == acc_pkg::SENSE_TOGGLE // R3
        && chk_neg0 != acc_pkg::NEG_RSVD |=> evt[0] == (rise[0] || fall[0]))
        else $error("toggle event mismatch on unit 0");

    // Rising sensitivity ignores falls.
    a_rise_only: assert property (chk_sense0 == acc_pkg::SENSE_RISE // R3
        |=> !evt[0] || rise[0])
        else $error("event without rise on unit 0");

    // Falling sensitivity ignores rises.
    a_fall_only: assert property (chk_sense0 == acc_pkg::SENSE_FALL // R3
        |=> !evt[0] || fall[0])
        else $error("event without fall on unit 0");

    // Reserved sensitivity never raises an event.
    a_sense_reserved: assert property (st.ctrl[1][acc_pkg::SENSE_HI:acc_pkg::SENSE_LO] // R15
        == acc_pkg::SENSE_RSVD |=> !evt[1])
        else $error("event under reserved sense");

    // A reserved source never raises an event.
    a_neg_reserved: assert property (chk_neg0 == acc_pkg::NEG_RSVD |=> !evt[0]) // R15
        else $error("event under reserved source");

    // A disabled comparator shows a low result.
    a_disabled_low: assert property (!unit_enable[0] |=> !compare_result_bit[0]) // R4
        else $error("result high while unit 0 disabled");

    // The enable follows a control write.
    a_enable_out: assert property (reg_write && reg_addr == acc_pkg::ADDR_CTRL0 // R4
        |=> unit_enable[0] == $past(reg_wdata[acc_pkg::ENABLE_POS]))
        else $error("enable not taken from write");

    // The clock select follows a control write.
    a_clock_select: assert property (reg_write && reg_addr == acc_pkg::ADDR_CTRL0 // R8
        |=> compare_clock_select == $past(reg_wdata[acc_pkg::BIT3_POS]))
        else $error("clock select not taken from write");

    // The source select follows a control write.
    a_neg_select: assert property (reg_write && reg_addr == acc_pkg::ADDR_CTRL1 // R2
        |=> negative_source_select[5:3] == $past(reg_wdata[acc_pkg::NEG_HI:0]))
        else $error("source select not taken from write");

    // Amplifier routing follows its register write.
    a_amp_route: assert property (reg_write && reg_addr == acc_pkg::ADDR_AMP // R13
        |=> amp_route == $past(reg_wdata[acc_pkg::AMP_UNITS-1:0]))
        else $error("amp route not taken from write");

    // Clearing the request enable drops the line at once.
    a_irq_blocked: assert property (reg_write && reg_addr == acc_pkg::ADDR_CTRL0 // R5
        && !reg_wdata[acc_pkg::IRQ_EN_POS] |=> !unit_irq[0])
        else $error("unit 0 request not blocked");

    // A line follows its own flag and enable.
    a_unit_irq_line: assert property (unit_irq[1] == (st.flag[1] // R5
        && st.ctrl[1][acc_pkg::IRQ_EN_POS]))
        else $error("unit 1 request mismatch");

    // An allowed event raises the unit's own line.
    a_unit_irq_own: assert property (evt[0] && st.ctrl[0][acc_pkg::IRQ_EN_POS] // R6
        && !reg_write |=> unit_irq[0])
        else $error("unit 0 request missing after event");

    // An unmasked flag keeps the shared interrupt high.
    a_irq_held: assert property (st.flag[0] && st.mask[0] && !irq_ack[0] // R14
        && !reg_write |=> irq)
        else $error("shared interrupt dropped");

    // Each event reaches the converter trigger.
    a_trigger: assert property (evt[1] |=> conversion_trigger[1]) // R7
        else $error("trigger 1 missing after event");

    // With routing off the timer sees nothing.
    a_capture_off: assert property (!st.ctrl[1][acc_pkg::BIT3_POS] |=> // R11
        !capture_event && !capture_input)
        else $error("capture active without routing");

    // With routing on the timer input follows the result.
    a_capture_level: assert property (st.ctrl[1][acc_pkg::BIT3_POS] // R9
        |=> capture_input == $past(compare_result_bit[1]))
        else $error("capture input does not follow result");

    // A routed rise with rising select captures.
    a_capture_rise: assert property (st.ctrl[1][acc_pkg::BIT3_POS] // R10
        && timer_capture_edge_select && rise[1] |=> capture_event)
        else $error("rising capture missed");

    // The same seen from the result bit itself.
    a_capture_seq: assert property (s_rise1_routed ##0 timer_capture_edge_select // R10
        |=> capture_event)
        else $error("routed rise gave no capture");

    // A routed fall with falling select captures.
    a_capture_fall: assert property (st.ctrl[1][acc_pkg::BIT3_POS] // R10
        && !timer_capture_edge_select && fall[1] |=> capture_event)
        else $error("falling capture missed");

    // With rising select, only a rise captures.
    a_capture_edge: assert property (timer_capture_edge_select && !rise[1] // R10
        |=> !capture_event)
        else $error("capture on the wrong edge");

    // Control reads return the register one cycle on.
    a_rdata_ctrl: assert property (reg_read && reg_addr == acc_pkg::ADDR_CTRL1 // R9
        |=> reg_rdata == $past(st.ctrl[1]))
        else $error("control 1 read mismatch");

    // Status reads return the results one cycle on.
    a_rdata_status: assert property (reg_read && reg_addr == acc_pkg::ADDR_STATUS // R1
        |=> reg_rdata[3:0] == $past(compare_result_bit))
        else $error("status read mismatch");

    // Control registers come out of reset cleared.
    a_reset_zero: assert property ($fell(reset) |-> st.ctrl[0] == 8'h00 // R16
        && st.ctrl[1] == 8'h00)
        else $error("control not zero after reset");
endmodule : acc_control

// ---- acc_edge_detect.sv ----
// Synchroniser and output event detector for one comparator.
module acc_edge_detect (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic reset,
    // Raw comparator output and its settings.
    input wire logic raw_in,
    input wire logic enable,
    input wire logic [1:0] sense,
    input wire logic [2:0] neg_sel,
    // Synchronised result and events.
    output logic result,
    output logic event_pulse,
    output logic rise,
    output logic fall
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic res;
        logic evt;
        logic rise;
        logic fall;
    } acc_edge_t;

    acc_edge_t st;
    acc_edge_t next_st;

    // The first stage only feeds the second, so metastability never reaches the edge logic.
    always_comb begin
        logic cur;
        logic up;
        logic dn;
        logic hit;
        next_st = st;
        hit = 1'b0;
        cur = enable & st.s2;
        up = cur & ~st.res;
        dn = ~cur & st.res;
        next_st.s1 = raw_in;
        next_st.s2 = st.s1;
        next_st.res = cur; // R1 R4
        unique case (sense)
            acc_pkg::SENSE_TOGGLE: hit = up | dn; // R3
            acc_pkg::SENSE_FALL: hit = dn; // R3
            acc_pkg::SENSE_RISE: hit = up; // R3
            acc_pkg::SENSE_RSVD: hit = 1'b0; // R15
        endcase
        // A reserved source code cannot be trusted, so it raises no event.
        next_st.evt = hit & (neg_sel != acc_pkg::NEG_RSVD); // R15
        next_st.rise = up;
        next_st.fall = dn;
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign result = st.res;
    assign event_pulse = st.evt;
    assign rise = st.rise;
    assign fall = st.fall;
endmodule : acc_edge_detect

// ---- acc_pkg.sv ----
// Constants for the analog comparator control block.
package acc_pkg;
    localparam int UNITS = 4;
    localparam int DW = 8;
    localparam int AW = 3;
    // Register addresses.
    localparam logic [2:0] ADDR_CTRL0 = 3'h0;
    localparam logic [2:0] ADDR_CTRL1 = 3'h1;
    localparam logic [2:0] ADDR_CTRL2 = 3'h2;
    localparam logic [2:0] ADDR_CTRL3 = 3'h3;
    localparam logic [2:0] ADDR_STATUS = 3'h4;
    localparam logic [2:0] ADDR_MASK = 3'h5;
    localparam logic [2:0] ADDR_AMP = 3'h6;
    // Control register fields.
    localparam int ENABLE_POS = 7;
    localparam int IRQ_EN_POS = 6;
    localparam int SENSE_HI = 5;
    localparam int SENSE_LO = 4;
    localparam int BIT3_POS = 3;
    localparam int NEG_HI = 2;
    // Status register layout: flags above, results below.
    localparam int FLAG_POS = 4;
    localparam int RESULT_POS = 0;
    localparam int AMP_UNITS = 3;
    // Reset values.
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [3:0] FLAG_RESET = 4'h0;
    localparam logic [3:0] MASK_RESET = 4'h0;
    localparam logic [2:0] AMP_RESET = 3'h0;
    // Mask of writable bits for units that own no bit 3.
    localparam logic [7:0] CTRL_PLAIN_MASK = 8'hf7;
    // Sensitivity codes.
    localparam logic [1:0] SENSE_TOGGLE = 2'h0;
    localparam logic [1:0] SENSE_RSVD = 2'h1;
    localparam logic [1:0] SENSE_FALL = 2'h2;
    localparam logic [1:0] SENSE_RISE = 2'h3;
    // Negative source codes.
    localparam logic [2:0] NEG_REF_DIV640 = 3'h0;
    localparam logic [2:0] NEG_REF_DIV320 = 3'h1;
    localparam logic [2:0] NEG_REF_DIV213 = 3'h2;
    localparam logic [2:0] NEG_REF_DIV160 = 3'h3;
    localparam logic [2:0] NEG_BANDGAP = 3'h4;
    localparam logic [2:0] NEG_DAC = 3'h5;
    localparam logic [2:0] NEG_PIN = 3'h6;
    localparam logic [2:0] NEG_RSVD = 3'h7;
endpackage : acc_pkg

// ---- testbench.sv ----
// Self-checking bench for the comparator control block.
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    // Expected result of unit 1 at 1000 mV for selector codes 0..6.
    localparam logic [6:0] SEL_EXP = 7'h23;
    localparam logic [3:0] RISE_EXP = 4'h9;
    localparam logic [3:0] FALL_EXP = 4'h5;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [3:0] irq_ack = 4'h0;
    logic tes = 1'b0;
    logic [7:0] reg_rdata;
    logic [3:0] compare_raw, unit_enable, crb, unit_irq, ctrig;
    logic [11:0] nss;
    logic [2:0] amp_route;
    logic ccs, irq, capture_input, capture_event;
    int pos_mv [acc_pkg::UNITS] = '{100, 100, 100, 100};
    int fails = 0;
    int comparisons = 0;
    int cap_cnt = 0;
    int base;

    acc_control dut_u (.clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .compare_raw(compare_raw), .irq_ack(irq_ack),
        .timer_capture_edge_select(tes), .unit_enable(unit_enable),
        .negative_source_select(nss), .compare_clock_select(ccs), .amp_route(amp_route),
        .compare_result_bit(crb), .unit_irq(unit_irq), .conversion_trigger(ctrig),
        .irq(irq), .capture_input(capture_input), .capture_event(capture_event));
    acc_analog_model model_u (.negative_source_select(nss), .pos_mv(pos_mv),
        .compare_raw(compare_raw));

    // Clock of 50 ns period.
    always #25 clk_sys = ~clk_sys;

    // Capture pulses are counted so that a missing or doubled pulse shows.
    // The count stands in for a timer whose capture mask software has set.
    always @(posedge clk_sys) begin
        if (capture_event === 1'b1) cap_cnt <= cap_cnt + 1;
    end

    task automatic finish_test();
        if (fails == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", name, exp, got);
            fails++;
        end
    endtask : chk

    // Waits n edges, then lets their updates land.
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : cyc

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk_sys);
        reg_write <= 1'b0;
    endtask : wr

    task automatic rd(input logic [2:0] a, input logic [7:0] exp, input string name);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk_sys);
        reg_read <= 1'b0;
        #1;
        chk(name, exp, reg_rdata);
    endtask : rd

    // Six cycles cover the synchroniser and flag latency.
    task automatic setp(input int i, input int v);
        @(posedge clk_sys);
        pos_mv[i] <= v;
        cyc(6);
    endtask : setp

    // Main sequence.
    initial begin
        repeat (8) @(posedge clk_sys);
        reset <= 1'b0;
        for (int a = 0; a < 8; a++) rd(a[2:0], 8'h00, "reset value");
        wr(3'h0, 8'hff);
        wr(3'h2, 8'hff);
        wr(3'h7, 8'hff);
        wr(3'h6, 8'h05);
        rd(3'h0, 8'hff, "ctrl0");
        rd(3'h2, 8'hf7, "ctrl2");
        rd(3'h7, 8'h00, "unmapped");
        chk("clock select", 8'h01, {7'h0, ccs});
        chk("enables", 8'h05, {4'h0, unit_enable});
        chk("neg select", 8'h07, {5'h0, nss[2:0]});
        chk("amp route", 8'h05, {5'h0, amp_route});
        rd(3'h6, 8'h05, "amp reg");
        wr(3'h0, 8'h00);
        wr(3'h2, 8'h00);
        // Each sensitivity code sees one rise and one fall.
        for (int k = 0; k < 4; k++) begin
            wr(3'h0, {2'h2, k[1:0] == 2'h0 ? acc_pkg::SENSE_TOGGLE : k[1:0] == 2'h1 ?
                acc_pkg::SENSE_RSVD : k[1:0] == 2'h2 ? acc_pkg::SENSE_FALL :
                acc_pkg::SENSE_RISE, 4'h0});
            setp(0, 2000);
            rd(3'h4, {3'h0, RISE_EXP[k], 4'h1}, "rise flag");
            wr(3'h4, 8'h10);
            setp(0, 100);
            rd(3'h4, {3'h0, FALL_EXP[k], 4'h0}, "fall flag");
            wr(3'h4, 8'h10);
        end
        // Selector sweep with reserved sensitivity, so no flag may rise.
        wr(3'h1, 8'h90);
        setp(1, 1000);
        for (int s = 0; s < 7; s++) begin
            wr(3'h1, {5'h12, s[2:0]});
            cyc(6);
            chk("result1", {7'h0, SEL_EXP[s]}, {7'h0, crb[1]});
        end
        rd(3'h4, 8'h00, "no reserved flag");
        // Interrupt gating, mask and service clear.
        wr(3'h0, 8'hc0);
        setp(0, 2000);
        chk("unit irq", 8'h01, {4'h0, unit_irq});
        chk("trigger", 8'h01, {4'h0, ctrig});
        chk("masked irq", 8'h00, {7'h0, irq});
        wr(3'h5, 8'h01);
        cyc(1);
        chk("irq", 8'h01, {7'h0, irq});
        rd(3'h5, 8'h01, "mask reg");
        wr(3'h0, 8'h80);
        cyc(1);
        chk("irq blocked", 8'h00, {4'h0, unit_irq});
        wr(3'h0, 8'hc0);
        @(posedge clk_sys);
        irq_ack <= 4'h1;
        @(posedge clk_sys);
        irq_ack <= 4'h0;
        cyc(1);
        chk("irq cleared", 8'h00, {7'h0, irq});
        rd(3'h4, 8'h01, "serviced flag");
        // Capture routing off, then rising and falling capture edges.
        wr(3'h1, 8'h80);
        setp(1, 100);
        base = cap_cnt;
        setp(1, 2000);
        chk("unrouted", 8'h00, 8'(cap_cnt - base));
        chk("capture off", 8'h00, {7'h0, capture_input});
        wr(3'h1, 8'h88);
        @(posedge clk_sys);
        tes <= 1'b1;
        setp(1, 100);
        setp(1, 2000);
        chk("rise capture", 8'h01, 8'(cap_cnt - base));
        chk("capture input", 8'h01, {7'h0, capture_input});
        @(posedge clk_sys);
        tes <= 1'b0;
        setp(1, 100);
        chk("fall capture", 8'h02, 8'(cap_cnt - base));
        finish_test();
    end

    // A hang counts as a mismatch.
    initial begin
        #2000000;
        fails++;
        finish_test();
    end
endmodule : testbench
